// *** rtl/cem_pkg.sv ***
// Package for the camera error-code memory: codes, sizes and fault slot order.
// Assumes a single system clock domain; no software-mapped registers.
package cem_pkg;

    localparam int          CEM_CODE_W        = 3;
    localparam int          CEM_NUM_FAULTS    = 5;
    localparam int          CEM_DEPTH_W       = 3;

    localparam logic [2:0]  CEM_CODE_NONE     = 3'h0;
    localparam logic [2:0]  CEM_CODE_OVERTRIG = 3'h1;
    localparam logic [2:0]  CEM_CODE_SETLOAD  = 3'h2;
    localparam logic [2:0]  CEM_CODE_BADPARAM = 3'h3;
    localparam logic [2:0]  CEM_CODE_POWER    = 3'h5;
    localparam logic [2:0]  CEM_CODE_TRIGW    = 3'h6;

    localparam logic [2:0]  CEM_DEPTH_ZERO    = 3'h0;
    localparam logic [2:0]  CEM_DEPTH_ONE     = 3'h1;

    localparam logic [15:0] CEM_CNT_ZERO      = 16'h0000;
    localparam logic [15:0] CEM_CNT_ONE       = 16'h0001;
    localparam logic [15:0] CEM_CNT_MAX       = 16'hFFFF;

    localparam int          CEM_SLOT_OVERTRIG = 0;
    localparam int          CEM_SLOT_SETLOAD  = 1;
    localparam int          CEM_SLOT_BADPARAM = 2;
    localparam int          CEM_SLOT_POWER    = 3;
    localparam int          CEM_SLOT_TRIGW    = 4;

    typedef enum {
        CEM_IDLE,
        CEM_HOLD
    } cem_pulse_state_t;

endpackage : cem_pkg

// *** rtl/cem_pulse_check.sv ***
// Trigger-width checker: flags a trigger pulse shorter than the minimum width.
// Assumes the trigger input is synchronous to the system clock.
`timescale 1ns/1ps
module cem_pulse_check
    import cem_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_enable,
    input  wire logic [15:0] i_min_cycles,
    input  wire logic        i_trig,
    output logic             o_short
);

    cem_pulse_state_t state_r;
    cem_pulse_state_t state_nxt;
    logic [15:0]      cnt_r;
    logic [15:0]      cnt_nxt;
    logic             short_nxt;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        short_nxt = 1'b0;
        case (state_r)
            CEM_IDLE:
            begin
                if (i_enable && i_trig)
                begin
                    state_nxt = CEM_HOLD;
                    cnt_nxt   = CEM_CNT_ONE;
                end
            end
            CEM_HOLD:
            begin
                if (i_trig)
                begin
                    if (cnt_r != CEM_CNT_MAX)
                        cnt_nxt = cnt_r + CEM_CNT_ONE;
                end
                else
                begin
                    state_nxt = CEM_IDLE;
                    short_nxt = i_enable && (cnt_r < i_min_cycles);
                end
            end
            default:
                state_nxt = CEM_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_r <= CEM_IDLE;
            cnt_r   <= CEM_CNT_ZERO;
            o_short <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            o_short <= short_nxt;
        end
    end

endmodule : cem_pulse_check

// *** rtl/cem_error_memory.sv ***
// Error-code memory: records one entry per fault type in order of detection,
// shows the newest code and removes it on a clear command.
// Assumes all inputs are synchronous to the system clock; fault inputs are pulses or levels.
`timescale 1ns/1ps
module cem_error_memory
    import cem_pkg::*;
(
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_nrst,
    input  wire logic                  i_acq_trig,
    input  wire logic                  i_acq_waiting,
    input  wire logic                  i_frame_trig,
    input  wire logic                  i_frame_waiting,
    input  wire logic                  i_set_load_fail,
    input  wire logic                  i_param_invalid,
    input  wire logic                  i_power_low,
    input  wire logic                  i_trig_width_mode,
    input  wire logic [15:0]           i_min_exp_cycles,
    input  wire logic                  i_exp_trig,
    input  wire logic                  i_clear_last,
    output logic      [CEM_CODE_W-1:0] o_last_error,
    output logic      [CEM_DEPTH_W-1:0] o_depth
);

    logic [CEM_CODE_W-1:0]                      stack_r [CEM_NUM_FAULTS];
    logic [CEM_CODE_W-1:0]                      stack_nxt [CEM_NUM_FAULTS];
    logic [CEM_DEPTH_W-1:0]                     depth_r;
    logic [CEM_DEPTH_W-1:0]                     depth_nxt;
    logic [CEM_NUM_FAULTS-1:0]                  present_r;
    logic [CEM_NUM_FAULTS-1:0]                  present_nxt;
    logic [CEM_NUM_FAULTS-1:0]                  fault_hit;
    logic [CEM_CODE_W-1:0]                      last_nxt;
    logic                                       trig_short;
    logic                                       acq_over;
    logic                                       frame_over;
    logic                                       pop_en;
    logic [CEM_DEPTH_W-1:0]                     top_idx;
    logic [CEM_DEPTH_W-1:0]                     pop_depth;
    logic [CEM_NUM_FAULTS-1:0]                  pop_mask;
    logic [CEM_NUM_FAULTS-1:0]                  kept;
    logic [CEM_NUM_FAULTS-1:0]                  push_en;
    logic [CEM_NUM_FAULTS-1:0][CEM_DEPTH_W-1:0] push_pos;

    // Slot order sets the code and the storing order within one cycle
    function automatic logic [CEM_CODE_W-1:0] slot_code(input int idx);
        case (idx)
            CEM_SLOT_OVERTRIG: slot_code = CEM_CODE_OVERTRIG;
            CEM_SLOT_SETLOAD:  slot_code = CEM_CODE_SETLOAD;
            CEM_SLOT_BADPARAM: slot_code = CEM_CODE_BADPARAM;
            CEM_SLOT_POWER:    slot_code = CEM_CODE_POWER;
            default:           slot_code = CEM_CODE_TRIGW;
        endcase
    endfunction : slot_code

    // Presence slot of a stored code
    function automatic int code_slot(input logic [CEM_CODE_W-1:0] code);
        case (code)
            CEM_CODE_OVERTRIG: code_slot = CEM_SLOT_OVERTRIG;
            CEM_CODE_SETLOAD:  code_slot = CEM_SLOT_SETLOAD;
            CEM_CODE_BADPARAM: code_slot = CEM_SLOT_BADPARAM;
            CEM_CODE_POWER:    code_slot = CEM_SLOT_POWER;
            default:           code_slot = CEM_SLOT_TRIGW;
        endcase
    endfunction : code_slot

    // One-hot presence bit of a stored code
    function automatic logic [CEM_NUM_FAULTS-1:0] slot_mask(input logic [CEM_CODE_W-1:0] code);
        slot_mask                  = '0;
        slot_mask[code_slot(code)] = 1'b1;
    endfunction : slot_mask

    // Index of the newest entry, held at zero for an empty memory
    function automatic logic [CEM_DEPTH_W-1:0] depth_below(input logic [CEM_DEPTH_W-1:0] depth);
        if (depth == CEM_DEPTH_ZERO)
            depth_below = CEM_DEPTH_ZERO;
        else
            depth_below = depth - CEM_DEPTH_ONE;
    endfunction : depth_below

    // Next free position after an optional push
    function automatic logic [CEM_DEPTH_W-1:0] depth_step(input logic [CEM_DEPTH_W-1:0] depth,
                                                          input logic                   push);
        if (push)
            depth_step = depth + CEM_DEPTH_ONE;
        else
            depth_step = depth;
    endfunction : depth_step

    // New content of one entry: the code pushed onto it, else the old code
    function automatic logic [CEM_CODE_W-1:0] entry_value(
        input logic [CEM_DEPTH_W-1:0]                     idx,
        input logic [CEM_CODE_W-1:0]                      old,
        input logic [CEM_NUM_FAULTS-1:0]                  en,
        input logic [CEM_NUM_FAULTS-1:0][CEM_DEPTH_W-1:0] pos
    );
        entry_value = old;
        for (int i = 0; i < CEM_NUM_FAULTS; i++)
        begin
            if (en[i] && (pos[i] == idx))
                entry_value = slot_code(i);
        end
    endfunction : entry_value

    cem_pulse_check u_pulse_check (
        .i_sys_clk    (i_sys_clk),
        .i_nrst       (i_nrst),
        .i_enable     (i_trig_width_mode),
        .i_min_cycles (i_min_exp_cycles),
        .i_trig       (i_exp_trig),
        .o_short      (trig_short)
    );

    // Fault decode, one presence slot per code
    assign acq_over                     = i_acq_trig && !i_acq_waiting;
    assign frame_over                   = i_frame_trig && !i_frame_waiting;
    assign fault_hit[CEM_SLOT_OVERTRIG] = acq_over || frame_over;
    assign fault_hit[CEM_SLOT_SETLOAD]  = i_set_load_fail;
    assign fault_hit[CEM_SLOT_BADPARAM] = i_param_invalid;
    assign fault_hit[CEM_SLOT_POWER]    = i_power_low;
    assign fault_hit[CEM_SLOT_TRIGW]    = trig_short;

    // Clear pops first, then new faults push, so a fault in the clear cycle is kept
    assign pop_en    = i_clear_last && (depth_r != CEM_DEPTH_ZERO);
    assign top_idx   = depth_below(depth_r);
    assign pop_depth = pop_en ? top_idx : depth_r;
    assign pop_mask  = pop_en ? slot_mask(stack_r[top_idx]) : '0;
    assign kept      = present_r & ~pop_mask;

    // Faults push in slot order onto consecutive entries
    assign push_en                      = fault_hit & ~kept;
    assign push_pos[CEM_SLOT_OVERTRIG]  = pop_depth;
    assign push_pos[CEM_SLOT_SETLOAD]   = depth_step(push_pos[CEM_SLOT_OVERTRIG], push_en[CEM_SLOT_OVERTRIG]);
    assign push_pos[CEM_SLOT_BADPARAM]  = depth_step(push_pos[CEM_SLOT_SETLOAD], push_en[CEM_SLOT_SETLOAD]);
    assign push_pos[CEM_SLOT_POWER]     = depth_step(push_pos[CEM_SLOT_BADPARAM], push_en[CEM_SLOT_BADPARAM]);
    assign push_pos[CEM_SLOT_TRIGW]     = depth_step(push_pos[CEM_SLOT_POWER], push_en[CEM_SLOT_POWER]);
    assign depth_nxt                    = depth_step(push_pos[CEM_SLOT_TRIGW], push_en[CEM_SLOT_TRIGW]);
    assign present_nxt                  = kept | push_en;

    // Entry contents after this cycle's pushes
    for (genvar k = 0; k < CEM_NUM_FAULTS; k++)
    begin : g_entry
        assign stack_nxt[k] = entry_value(CEM_DEPTH_W'(k), stack_r[k], push_en, push_pos);
    end

    // Newest code after pop and pushes
    assign last_nxt = (depth_nxt == CEM_DEPTH_ZERO) ? CEM_CODE_NONE
                                                    : stack_nxt[depth_below(depth_nxt)];

    // Entry store
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            for (int i = 0; i < CEM_NUM_FAULTS; i++)
                stack_r[i] <= CEM_CODE_NONE;
        end
        else
        begin
            stack_r <= stack_nxt;
        end
    end

    // Entry count
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            depth_r <= CEM_DEPTH_ZERO;
        end
        else
        begin
            depth_r <= depth_nxt;
        end
    end

    // Stored fault types
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            present_r <= '0;
        end
        else
        begin
            present_r <= present_nxt;
        end
    end

    // Newest code output
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_last_error <= CEM_CODE_NONE;
        end
        else
        begin
            o_last_error <= last_nxt;
        end
    end

    // Entry count output
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_depth <= CEM_DEPTH_ZERO;
        end
        else
        begin
            o_depth <= depth_nxt;
        end
    end

endmodule : cem_error_memory

// *** test/cem_error_memory_asserts.sv ***
// Checker for the error-code memory, watching its ports only.
// Assumes one clock domain; bound to every cem_error_memory instance.
`timescale 1ns/1ps
module cem_chk
    import cem_pkg::*;
(
    input wire logic                   i_sys_clk,
    input wire logic                   i_nrst,
    input wire logic                   i_acq_trig,
    input wire logic                   i_acq_waiting,
    input wire logic                   i_frame_trig,
    input wire logic                   i_frame_waiting,
    input wire logic                   i_set_load_fail,
    input wire logic                   i_param_invalid,
    input wire logic                   i_power_low,
    input wire logic                   i_trig_width_mode,
    input wire logic                   i_clear_last,
    input wire logic [CEM_CODE_W-1:0]  o_last_error,
    input wire logic [CEM_DEPTH_W-1:0] o_depth
);
    logic tw_r;
    always_ff @(posedge i_sys_clk or negedge i_nrst)
        if (!i_nrst) tw_r <= 1'b0;
        else tw_r <= i_trig_width_mode;
    wire ot = (i_acq_trig && !i_acq_waiting) || (i_frame_trig && !i_frame_waiting);
    wire q3 = !ot && !i_set_load_fail && !i_power_low && !i_trig_width_mode && !tw_r;
    wire q  = q3 && !i_param_invalid;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    sequence s_clr; i_clear_last && q && o_depth != 3'h0; endsequence
    property p_no4; o_last_error != 3'h4; endproperty
    a_no4: assert property (p_no4) else $error("code 4 shown");
    property p_empty; (o_depth == 3'h0) == (o_last_error == 3'h0); endproperty
    a_empty: assert property (p_empty) else $error("empty code mismatch");
    property p_max; o_depth <= 3'h5; endproperty
    a_max: assert property (p_max) else $error("too many entries");
    property p_pop; s_clr |=> o_depth == $past(o_depth) - 3'h1; endproperty
    a_pop: assert property (p_pop) else $error("clear did not pop");
    property p_hold; q && !i_clear_last |=> $stable(o_depth) && $stable(o_last_error); endproperty
    a_hold: assert property (p_hold) else $error("state moved idle");
    property p_pwr;
        i_power_low && !i_trig_width_mode && !tw_r && !i_clear_last && o_depth == 3'h0 |=> o_last_error == 3'h5;
    endproperty
    a_pwr: assert property (p_pwr) else $error("power code wrong");
    property p_par;
        i_param_invalid && q3 && !i_clear_last && o_depth == 3'h0 |=> o_last_error == 3'h3 && o_depth == 3'h1;
    endproperty
    a_par: assert property (p_par) else $error("param code wrong");
    property p_rep; i_param_invalid && q3 && !i_clear_last && o_last_error == 3'h3 |=> $stable(o_depth); endproperty
    a_rep: assert property (p_rep) else $error("repeat stored twice");
endmodule : cem_chk
bind cem_error_memory cem_chk u_chk (.i_sys_clk, .i_nrst, .i_acq_trig, .i_acq_waiting, .i_frame_trig,
    .i_frame_waiting, .i_set_load_fail, .i_param_invalid, .i_power_low, .i_trig_width_mode,
    .i_clear_last, .o_last_error, .o_depth);

// *** test/tb_top.sv ***
// Self-checking bench for the error-code memory.
// Assumes one 250 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module tb_top
    import cem_pkg::*;
;
    logic clk = 1'b0, nrst = 1'b0, clr = 1'b0, acq = 1'b0, aw = 1'b0, frm = 1'b0, fw = 1'b0;
    logic setf = 1'b0, par = 1'b0, pwr = 1'b0, twm = 1'b0, trg = 1'b0;
    logic [15:0] minw = 16'h0004;
    logic [2:0]  code, depth;
    int          error_cnt = 0, checked = 0;
    logic [9:0]  rows [7] = '{10'b00_10000_001, 10'b00_01000_001, 10'b00_00100_010, 10'b00_00010_011,
                              10'b00_00001_101, 10'b10_10000_000, 10'b01_01000_000};
    always #2 clk = ~clk;
    cem_error_memory uut (.i_sys_clk(clk), .i_nrst(nrst), .i_acq_trig(acq), .i_acq_waiting(aw),
        .i_frame_trig(frm), .i_frame_waiting(fw), .i_set_load_fail(setf), .i_param_invalid(par),
        .i_power_low(pwr), .i_trig_width_mode(twm), .i_min_exp_cycles(minw), .i_exp_trig(trg),
        .i_clear_last(clr), .o_last_error(code), .o_depth(depth));
    task drive(input logic [6:0] v);
        {clr, acq, frm, setf, par, pwr, trg} = v;
        @(negedge clk);
    endtask : drive
    task chk(input logic [2:0] ec, input logic [2:0] ed);
        checked++;
        if (code !== ec || depth !== ed)
        begin
            error_cnt++;
            $display("FAIL last_error/depth exp %0h/%0h got %0h/%0h", ec, ed, code, depth);
        end
    endtask : chk
    task print_verdict;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    initial
    begin
        #20000;
        error_cnt++;
        print_verdict;
    end
    initial
    begin
        repeat (10) @(negedge clk);
        chk(3'h0, 3'h0);
        nrst = 1'b1;
        @(negedge clk);
        foreach (rows[i])
        begin
            {aw, fw} = rows[i][9:8];
            drive({1'b0, rows[i][7:3], 1'b0});
            chk(rows[i][2:0], {2'b0, rows[i][2:0] != 3'h0});
            drive(7'h40);
            chk(3'h0, 3'h0);
        end
        {aw, fw} = 2'b00;
        drive(7'h02);
        drive(7'h04);
        drive(7'h04);
        chk(3'h3, 3'h2);
        drive(7'h08);
        chk(3'h2, 3'h3);
        drive(7'h42);
        chk(3'h3, 3'h2);
        drive(7'h40);
        chk(3'h5, 3'h1);
        drive(7'h04);
        chk(3'h3, 3'h2);
        repeat (3) drive(7'h40);
        chk(3'h0, 3'h0);
        twm = 1'b1;
        repeat (4) drive(7'h01);
        repeat (3) drive(7'h00);
        chk(3'h0, 3'h0);
        repeat (3) drive(7'h01);
        repeat (2) drive(7'h00);
        chk(3'h6, 3'h1);
        twm = 1'b0;
        repeat (2) drive(7'h01);
        repeat (2) drive(7'h00);
        chk(3'h6, 3'h1);
        drive(7'h3E);
        chk(3'h5, 3'h5);
        drive(7'h42);
        chk(3'h5, 3'h5);
        drive(7'h40);
        chk(3'h3, 3'h4);
        repeat (4) drive(7'h40);
        chk(3'h0, 3'h0);
        minw = 16'h0002;
        twm  = 1'b1;
        drive(7'h01);
        repeat (2) drive(7'h00);
        chk(3'h6, 3'h1);
        twm = 1'b0;
        nrst = 1'b0;
        #1;
        chk(3'h0, 3'h0);
        @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        chk(3'h0, 3'h0);
        drive(7'h04);
        chk(3'h3, 3'h1);
        print_verdict;
    end
endmodule : tb_top
